// [pkg/vme_consts.svh]
// constants of the video encoder mode register bank
`ifndef VME_CONSTS_SVH
`define VME_CONSTS_SVH

// sub-addresses of the two mode registers
`define VME_SUB_PRIMARY   8'h00
`define VME_SUB_SECONDARY 8'h01

// mode_select_primary field positions
`define VME_PRI_OVERRIDE  7
`define VME_PRI_CHROMA    6
`define VME_PRI_DAC_SLEEP 5
`define VME_PRI_RGB       4

// mode_select_secondary field positions
`define VME_SEC_SETUP     7
`define VME_SEC_COUNTER   6
`define VME_SEC_RGB_LEVEL 5
`define VME_SEC_OUTPUT_FORMAT_SELECT    4
`define VME_SEC_MASTER    3
`define VME_SEC_SCAN      2
`define VME_SEC_GL_OFF    1
`define VME_SEC_GL_SEL    0

// reset value of both registers, every field zero
`define VME_REG_RESET     8'h00

// video mode codes with special meaning
`define VME_MODE_SERIAL   4'h0
`define VME_MODE_SLEEP    4'hF

// last field index of the colour sequence and genlock pulse width
`define VME_NTSC_LAST     3'h3
`define VME_PAL_LAST      3'h7
`define VME_GL_PULSE_CYC  2'h2

// seven-bit bus address of the device, arbitrary value
`define VME_DEV_ADDR      7'h45

// number of pin inputs passing the synchroniser
`define VME_SYNC_W        8

`endif

// [pkg/vme_pkg.sv]
// types and helpers shared by the mode register bank
`default_nettype none
package vme_pkg;

    // serial bus receiver states, gray coded along the write path
    typedef enum logic [2:0] {
        VME_IDLE     = 3'b000,
        VME_DEV      = 3'b001,
        VME_DEV_ACK  = 3'b011,
        VME_SUB      = 3'b010,
        VME_SUB_ACK  = 3'b110,
        VME_DATA     = 3'b111,
        VME_DATA_ACK = 3'b101,
        VME_SKIP     = 3'b100
    } vme_bus_e;

    // pixel-rate codes where the input colour select bit counts
    function automatic logic vme_is_pixel_rate(input logic [3:0] m);
        return (m == 4'h5) || (m == 4'h6) || (m == 4'h7) ||
               (m == 4'hD) || (m == 4'hE);
    endfunction

endpackage : vme_pkg
`default_nettype wire

// [pkg/vme_gl_if.sv]
// control and status between the register bank and the genlock unit
`default_nettype none
interface vme_gl_if;
    logic master;
    logic sel;
    logic off;
    logic pal;
    logic field_start;
    logic sync_fall;
    logic gl_in;
    logic gl_out;
    logic scph_reset;

    modport ctl (output master, sel, off, pal, field_start, sync_fall,
                 gl_in, input gl_out, scph_reset);
    modport gl  (input master, sel, off, pal, field_start, sync_fall,
                 gl_in, output gl_out, scph_reset);
endinterface : vme_gl_if
`default_nettype wire

// [logic/vme_sync.sv]
// two-stage synchroniser for asynchronous pin inputs
`default_nettype none
module vme_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // pins in, synchronised copy out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } vme_sync_s;

    vme_sync_s r_reg;
    vme_sync_s r_next;

    // the first stage feeds only the second stage
    always_comb begin
        r_next.meta = d_i;
        r_next.q    = r_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q_o = r_reg.q;
endmodule : vme_sync
`default_nettype wire

// [logic/vme_genlock.sv]
// genlock field sequencing and subcarrier phase reset
`include "vme_consts.svh"
`default_nettype none
module vme_genlock
    import vme_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control from the register bank
    vme_gl_if.gl      gl
);
    typedef struct packed {
        logic [2:0] field;
        logic       gl_prev;
        logic       armed;
        logic       sent;
        logic [1:0] pulse;
        logic       scph;
    } vme_gl_s;

    vme_gl_s r_reg;
    vme_gl_s r_next;
    logic    last;
    logic    ext;
    logic    on;

    // field counter, pulse generator and reset decision
    always_comb begin
        r_next         = r_reg;
        r_next.scph    = 1'b0;
        r_next.gl_prev = gl.gl_in;
        last = r_reg.field == (gl.pal ? `VME_PAL_LAST : `VME_NTSC_LAST);
        ext  = ~gl.sel;
        on   = ~gl.off;
        if (r_reg.pulse != 2'h0) begin
            r_next.pulse = r_reg.pulse - 2'h1;
        end
        if (gl.field_start) begin
            r_next.field = last ? 3'h0 : r_reg.field + 3'h1;
            r_next.sent  = 1'b0;
            // internal source: master always, slave with pin ignored
            if (on && last && (gl.master || gl.sel || r_reg.armed)) begin
                r_next.scph  = 1'b1;      // [RULE11] [RULE15] [RULE17]
                r_next.armed = 1'b0;
            end
        end
        // one field ahead of the reset, only with the pin selected
        if (gl.master && ext && on && last && gl.sync_fall &&
            !r_reg.sent && !gl.field_start) begin
            r_next.pulse = `VME_GL_PULSE_CYC;   // [RULE13] [RULE18]
            r_next.sent  = 1'b1;
        end
        // a slave arms on a rising pin; a pin held high never re-arms
        if (!gl.master && ext && on) begin
            if (gl.gl_in && !r_reg.gl_prev) begin
                r_next.field = 3'h0;      // [RULE12] [RULE14]
                r_next.armed = 1'b1;
            end
        end else begin
            r_next.armed = 1'b0;          // [RULE15]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign gl.gl_out     = r_reg.pulse != 2'h0;
    assign gl.scph_reset = r_reg.scph;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pulse_width: assert property ($rose(gl.gl_out) |-> // [RULE18]
        gl.gl_out ##1 gl.gl_out ##1 !gl.gl_out)
        else $error("genlock pulse not two cycles wide");
    a_pulse_gate: assert property ($rose(gl.gl_out) |-> // [RULE13]
        $past(gl.master && !gl.sel && !gl.off))
        else $error("genlock pulse outside master pin mode");
    a_gl_off: assert property (gl.off |=> !gl.scph_reset) // [RULE11]
        else $error("phase reset while genlock is off");
    a_sel_ignores: assert property (gl.sel |=> !r_reg.armed) // [RULE15]
        else $error("pin armed while the pin is ignored");
    a_slave_arms: assert property (!gl.master && !gl.sel && !gl.off && // [RULE14]
        gl.gl_in && !r_reg.gl_prev |=> r_reg.armed && r_reg.field == 3'h0)
        else $error("slave did not arm on genlock edge");

    c_master_pulse: cover property ($rose(gl.gl_out));
    c_phase_reset:  cover property (gl.scph_reset && r_reg.field == 3'h0);
endmodule : vme_genlock
`default_nettype wire

// [logic/vme_mode_regs.sv]
// write-only mode register bank of the video encoder with bus receiver
//
// Overview of operation
// [RULE1] override bit picks register or pin mode
// [RULE2] chroma bit: offset binary or two's complement
// [RULE3] converter sleep bit sleeps only converters
// [RULE4] colour select bit valid for pixel-rate codes
// [RULE5] NTSC codes decoded from mode field
// [RULE6] PAL codes decoded from mode field
// [RULE7] register mode never selects full sleep
// [RULE8] setup bit sets 7.5 IRE, NTSC only
// [RULE9] counter bit tolerates nonstandard line counts
// [RULE10] level bit selects limited RGB range
// [RULE11] genlock off bit disables phase reset
// [RULE12] select bit zero routes reset via pin
// [RULE13] master pulses one field early when on
// [RULE14] slave resets phase on pin pulse
// [RULE15] select bit one ignores pin entirely
// [RULE16] registers written only, never read back
// [RULE17] slave applies pulse at fourth/eighth field
// [RULE18] master pulse two clocks wide at sync fall
// [RULE19] all fields reset to zero
`include "vme_consts.svh"
`default_nettype none
module vme_mode_regs
    import vme_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `VME_DEV_ADDR
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // two-wire serial bus, data line open drain
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // mode strap pins
    input  wire logic [3:0] mode_pins_i,
    input  wire logic       input_color_select_i,
    // timing events from the encoder timing logic
    input  wire logic       field_start_i,
    input  wire logic       sync_fall_i,
    // genlock pin, two way
    input  wire logic       genlock_i,
    output logic            genlock_o,
    output logic            genlock_oe_o,
    // configuration to the datapath
    output logic [3:0]      video_mode_o,
    output logic            pal_o,
    output logic            input_rgb_o,
    output logic            chroma_twos_o,
    output logic            dac_sleep_o,
    output logic            logic_sleep_o,
    output logic            black_setup_o,
    output logic            nonstd_lines_o,
    output logic            rgb_limited_o,
    output logic            output_format_select_o,
    output logic            master_o,
    output logic            scan_type_select_o,
    output logic            scph_reset_o
);
    // whole state of the bank
    typedef struct packed {
        vme_bus_e   st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] sub;
        logic       scl_d;
        logic       sda_d;
        logic       sda_oe;
        logic [7:0] pri;
        logic [7:0] sec;
        logic [3:0] mode;
        logic       pal;
        logic       rgb_in;
        logic       chroma;
        logic       dac_sleep;
        logic       logic_sleep;
        logic       setup;
        logic       nonstd;
        logic       rgb_lim;
        logic       output_format_select;
        logic       master;
        logic       scan;
    } vme_top_s;

    vme_top_s                r_reg;
    vme_top_s                r_next;
    logic [`VME_SYNC_W-1:0]  pins;
    logic                    scl;
    logic                    sda;
    logic [3:0]              mode_pin;
    logic                    rgb_pin;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    bus_start;
    logic                    bus_stop;
    logic                    wr_fire;
    logic                    ovr;
    logic [3:0]              mode_eff;
    logic                    sleep_eff;

    vme_gl_if gl_bus ();

    // every pin from outside the clock domain is synchronised first
    vme_sync #(
        .W (`VME_SYNC_W)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({genlock_i, input_color_select_i, mode_pins_i,
                 sda_i, scl_i}),
        .q_o   (pins)
    );

    assign scl      = pins[0];
    assign sda      = pins[1];
    assign mode_pin = pins[5:2];
    assign rgb_pin  = pins[6];

    // bus conditions seen on the synchronised lines
    assign scl_rise  = scl & ~r_reg.scl_d;
    assign scl_fall  = ~scl & r_reg.scl_d;
    assign bus_start = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
    assign bus_stop  = scl & r_reg.scl_d & ~r_reg.sda_d & sda;
    assign wr_fire   = (r_reg.st == VME_DATA) && scl_fall &&
                       (r_reg.bit_cnt == 4'h8) && !bus_start && !bus_stop;

    // mode source: register when overridden, otherwise the pins
    assign ovr       = r_reg.pri[`VME_PRI_OVERRIDE];
    assign mode_eff  = ovr ? r_reg.pri[3:0] : mode_pin;     // [RULE1]
    // full sleep only from the pins, never from the register
    assign sleep_eff = ~ovr & ~rgb_pin &
                       (mode_pin == `VME_MODE_SLEEP);       // [RULE7]

    // bus receiver, register writes and output decode
    always_comb begin
        r_next       = r_reg;
        r_next.scl_d = scl;
        r_next.sda_d = sda;
        if (bus_start) begin
            r_next.st      = VME_DEV;
            r_next.bit_cnt = 4'h0;
            r_next.sda_oe  = 1'b0;
        end else if (bus_stop) begin
            r_next.st     = VME_IDLE;
            r_next.sda_oe = 1'b0;
        end else begin
            case (r_reg.st)
                VME_DEV, VME_SUB, VME_DATA: begin
                    if (scl_rise && r_reg.bit_cnt != 4'h8) begin
                        r_next.shreg   = {r_reg.shreg[6:0], sda};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && r_reg.bit_cnt == 4'h8) begin
                        r_next.sda_oe = 1'b1;
                        if (r_reg.st == VME_DEV) begin
                            // a read request is not acknowledged at all
                            if (r_reg.shreg[7:1] == DEV_ADDR &&
                                !r_reg.shreg[0]) begin
                                r_next.st = VME_DEV_ACK;
                            end else begin
                                r_next.st     = VME_SKIP;  // [RULE16]
                                r_next.sda_oe = 1'b0;
                            end
                        end else if (r_reg.st == VME_SUB) begin
                            r_next.sub = r_reg.shreg;
                            r_next.st  = VME_SUB_ACK;
                        end else begin
                            // sub-address steps so bursts fill both
                            r_next.sub = r_reg.sub + 8'h01;
                            r_next.st  = VME_DATA_ACK;
                        end
                    end
                end
                VME_DEV_ACK, VME_SUB_ACK, VME_DATA_ACK: begin
                    if (scl_fall) begin
                        r_next.sda_oe  = 1'b0;
                        r_next.bit_cnt = 4'h0;
                        r_next.st = (r_reg.st == VME_DEV_ACK) ?
                                    VME_SUB : VME_DATA;
                    end
                end
                VME_IDLE, VME_SKIP: begin
                    r_next.sda_oe = 1'b0;
                end
                default: begin
                    r_next.st     = VME_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end

        // other sub-addresses are acknowledged and dropped here
        if (wr_fire) begin
            if (r_reg.sub == `VME_SUB_PRIMARY) begin
                r_next.pri = r_reg.shreg;                   // [RULE16]
            end else if (r_reg.sub == `VME_SUB_SECONDARY) begin
                r_next.sec = r_reg.shreg;                   // [RULE16]
            end
        end

        // datapath configuration is registered once more for timing
        r_next.mode        = mode_eff;                      // [RULE1]
        r_next.pal         = mode_eff[3];                   // [RULE5] [RULE6]
        r_next.rgb_in      = (ovr ? r_reg.pri[`VME_PRI_RGB] : rgb_pin) &
                             vme_is_pixel_rate(mode_eff);   // [RULE4]
        r_next.chroma      = r_reg.pri[`VME_PRI_CHROMA];    // [RULE2]
        r_next.logic_sleep = sleep_eff;                     // [RULE7]
        r_next.dac_sleep   = r_reg.pri[`VME_PRI_DAC_SLEEP] |
                             sleep_eff;                     // [RULE3]
        r_next.setup       = r_reg.sec[`VME_SEC_SETUP] &
                             ~mode_eff[3];                  // [RULE8]
        r_next.nonstd      = r_reg.sec[`VME_SEC_COUNTER];   // [RULE9]
        r_next.rgb_lim     = r_reg.sec[`VME_SEC_RGB_LEVEL]; // [RULE10]
        r_next.output_format_select      = r_reg.sec[`VME_SEC_OUTPUT_FORMAT_SELECT];
        // the serial embedded-sync mode always runs as timing slave
        r_next.master      = r_reg.sec[`VME_SEC_MASTER] &
                             (mode_eff != `VME_MODE_SERIAL);
        r_next.scan        = r_reg.sec[`VME_SEC_SCAN];
    end

    // one register for the whole bank, all zero after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;                                    // [RULE19]
        end else begin
            r_reg <= r_next;
        end
    end

    // genlock control travels through the interface
    assign gl_bus.master      = r_reg.master;
    assign gl_bus.sel         = r_reg.sec[`VME_SEC_GL_SEL];
    assign gl_bus.off         = r_reg.sec[`VME_SEC_GL_OFF];
    assign gl_bus.pal         = r_reg.pal;
    assign gl_bus.field_start = field_start_i;
    assign gl_bus.sync_fall   = sync_fall_i;
    assign gl_bus.gl_in       = pins[7];

    vme_genlock u_genlock (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .gl    (gl_bus)
    );

    // bus outputs: the line is only ever pulled low
    assign sda_o    = 1'b0;
    assign sda_oe_o = r_reg.sda_oe;

    // genlock pin drives only in master mode
    assign genlock_o    = gl_bus.gl_out;
    assign genlock_oe_o = r_reg.master;                     // [RULE12]
    assign scph_reset_o = gl_bus.scph_reset;

    // configuration outputs straight from flip-flops
    assign video_mode_o           = r_reg.mode;
    assign pal_o                  = r_reg.pal;
    assign input_rgb_o            = r_reg.rgb_in;
    assign chroma_twos_o          = r_reg.chroma;
    assign dac_sleep_o            = r_reg.dac_sleep;
    assign logic_sleep_o          = r_reg.logic_sleep;
    assign black_setup_o          = r_reg.setup;
    assign nonstd_lines_o         = r_reg.nonstd;
    assign rgb_limited_o          = r_reg.rgb_lim;
    assign output_format_select_o = r_reg.output_format_select;
    assign master_o               = r_reg.master;
    assign scan_type_select_o     = r_reg.scan;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_mode_source: assert property ($past(ovr) |-> // [RULE1]
        video_mode_o == $past(r_reg.pri[3:0]))
        else $error("override set but mode not from register");
    a_pin_source: assert property (!$past(ovr) |-> // [RULE1]
        video_mode_o == $past(mode_pin))
        else $error("override clear but mode not from pins");
    a_chroma_fmt: assert property ( // [RULE2]
        chroma_twos_o == $past(r_reg.pri[`VME_PRI_CHROMA]))
        else $error("chroma format does not follow register");
    a_dac_sleep: assert property ( // [RULE3]
        $past(r_reg.pri[`VME_PRI_DAC_SLEEP]) |-> dac_sleep_o)
        else $error("converter sleep bit ignored");
    a_rgb_gate: assert property ( // [RULE4]
        input_rgb_o |-> vme_is_pixel_rate(video_mode_o))
        else $error("rgb input outside pixel-rate codes");
    a_ntsc_codes: assert property (!video_mode_o[3] |-> !pal_o) // [RULE5]
        else $error("ntsc code decoded as pal");
    a_pal_codes: assert property (video_mode_o[3] |-> pal_o) // [RULE6]
        else $error("pal code decoded as ntsc");
    a_reg_no_sleep: assert property ($past(ovr) |-> !logic_sleep_o) // [RULE7]
        else $error("register mode caused full sleep");
    a_setup_ntsc: assert property (pal_o |-> !black_setup_o) // [RULE8]
        else $error("black setup active in pal");
    a_counter_ctl: assert property ( // [RULE9]
        nonstd_lines_o == $past(r_reg.sec[`VME_SEC_COUNTER]))
        else $error("counter control not applied");
    a_rgb_range: assert property ( // [RULE10]
        rgb_limited_o == $past(r_reg.sec[`VME_SEC_RGB_LEVEL]))
        else $error("rgb level not applied");
    a_write_lands: assert property ( // [RULE16]
        wr_fire && r_reg.sub == `VME_SUB_PRIMARY |=>
        r_reg.pri == $past(r_reg.shreg) ##2 dac_sleep_o ==
        ($past(r_reg.pri[`VME_PRI_DAC_SLEEP], 2) | $past(sleep_eff)))
        else $error("write to primary register lost");
    a_read_refused: assert property ( // [RULE16]
        r_reg.st == VME_SKIP |-> !sda_oe_o)
        else $error("bus driven while not addressed");
    a_reset_zero: assert property (disable iff (1'b0) // [RULE19]
        $past(rst_i) |-> r_reg.pri == `VME_REG_RESET &&
        r_reg.sec == `VME_REG_RESET)
        else $error("register not zero after reset");

    c_write_pri: cover property (wr_fire && r_reg.sub == `VME_SUB_PRIMARY);
    c_write_sec: cover property (wr_fire &&
        r_reg.sub == `VME_SUB_SECONDARY);
    c_read_skip: cover property (r_reg.st == VME_SKIP);
endmodule : vme_mode_regs
`default_nettype wire

// [verif/vme_host_model.sv]
// two-wire bus host that writes the mode registers
`default_nettype none
module vme_host_model (
    // clock and bus lines
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acked;
    event stop_ev;

    // six clocks a half period, above the four the device needs
    task automatic half();
        repeat (6) @(negedge clk_i);
    endtask

    // gap after scl falls keeps sda moves clear of the scl edge
    task automatic put_bit(input logic b, output logic r);
        sda_low_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask

    // byte msb first, then the acknowledge slot released
    task automatic put_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        acked &= ~r;
    endtask

    // writes only, there is no read path
    task automatic write(input logic [6:0] a, input logic [7:0] s, d0, d1,
                         input int n);
        acked = 1'b1;
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b0;
        repeat (2) @(negedge clk_i);
        put_byte({a, 1'b0});
        put_byte(s);
        if (n > 0) put_byte(d0);
        if (n > 1) put_byte(d1);
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b0;
        half();
        -> stop_ev;
    endtask

    // bus idle with both lines released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        acked = 1'b0;
    end
endmodule // vme_host_model
`default_nettype wire

// [verif/vme_mode_regs_test.sv]
// self-checking bench for the mode register bank
`include "vme_consts.svh"
`default_nettype none
module vme_mode_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, scl, sda_low, oe, gl_drv, gl_o, gl_oe;
    logic        rgbp, fs, sf, scph, gl_prev, gl_pp;
    logic [3:0]  pins;
    logic [7:0]  pri, sec;
    logic [31:0] seed, cyc;
    logic [31:0] q[$];
    int          n_mismatch, checked;
    wire logic [14:0] cfg;
    logic [3:0]  codes [13] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6,
                                4'h7, 4'h8, 4'h9, 4'hA, 4'hD, 4'hE};
    // open drain data with pull-up, genlock pin owned by whoever enables
    wire logic sdao;
    wire logic sda = ~(sda_low | (oe & ~sdao));
    wire logic gl = gl_oe ? gl_o : gl_drv;

    vme_mode_regs uut (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sdao), .sda_oe_o(oe), .mode_pins_i(pins),
        .input_color_select_i(rgbp), .field_start_i(fs), .sync_fall_i(sf),
        .genlock_i(gl), .genlock_o(gl_o), .genlock_oe_o(gl_oe),
        .video_mode_o(cfg[14:11]), .pal_o(cfg[10]), .input_rgb_o(cfg[9]),
        .chroma_twos_o(cfg[8]), .dac_sleep_o(cfg[7]),
        .logic_sleep_o(cfg[6]), .black_setup_o(cfg[5]),
        .nonstd_lines_o(cfg[4]), .rgb_limited_o(cfg[3]),
        .output_format_select_o(cfg[2]), .master_o(cfg[1]),
        .scan_type_select_o(cfg[0]), .scph_reset_o(scph));
    vme_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));

    // 125 MHz clock and a cycle count for pulse notes
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected ack and outputs from register and pin model
    function automatic logic [15:0] exp_cfg(input logic ack);
        logic [3:0] m;
        logic ps;
        m = pri[7] ? pri[3:0] : pins;
        ps = !pri[7] && pins == 4'hF && !rgbp;
        return {ack, m, m[3], (pri[7] ? pri[4] : rgbp) &&
                (m inside {4'h5, 4'h6, 4'h7, 4'hD, 4'hE}), pri[6],
                pri[5] | ps, ps, sec[7] & ~m[3],
                sec[6:2] & {3'h7, m != 4'h0, 1'b1}};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a result with no note pending is always a mismatch
    task automatic take(input logic [31:0] seen);
        if (q.size() == 0) check("unnoted result", seen, 'x);
        else check("result", seen, q.pop_front());
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        pri = 8'h00;
        sec = 8'h00;
        repeat (4) @(negedge clk);
    endtask

    // notes go in before the write, the stop settles them
    task automatic send(input logic [6:0] a, input logic [7:0] s, d0, d1,
                        input int n);
        logic [15:0] e;
        e = exp_cfg(a == `VME_DEV_ADDR);
        q.push_back(e[15:9]);
        q.push_back(e[8:6]);
        q.push_back(e[5:0]);
        host.write(a, s, d0, d1, n);
    endtask

    task automatic fields(input int n, input logic note);
        for (int j = 0; j < n; j++) begin
            @(negedge clk);
            if (note && j == n - 1) q.push_back(cyc + 1);
            fs = 1'b1;
            @(negedge clk);
            fs = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask

    // phase reset and genlock pulse for one role and standard
    task automatic gl_case(input logic p, input logic [7:0] s);
        int last;
        last = p ? 7 : 3;
        do_reset();
        pri = {4'h8, p, 3'h1};
        sec = s;
        send(`VME_DEV_ADDR, 8'h00, pri, sec, 2);
        if (!s[3]) begin
            gl_drv = 1'b1;
            repeat (2) @(negedge clk);
            gl_drv = 1'b0;
            repeat (8) @(negedge clk);
            last++;
        end
        fields(last, !s[1] && !s[3]);
        if (s[3]) begin
            @(negedge clk);
            if (!s[1]) q.push_back(cyc + 1);
            sf = 1'b1;
            @(negedge clk);
            sf = 1'b0;
            fields(1, !s[1]);
        end
    endtask

    // configuration results appear at each stop
    always @(host.stop_ev) begin
        take({host.acked, cfg[14:9]});
        take(cfg[8:6]);
        take(cfg[5:0]);
    end

    // pulse results, plus the genlock pulse width
    always @(negedge clk) begin
        if (scph === 1'b1 || (gl_o === 1'b1 && gl_prev !== 1'b1))
            take(cyc);
        if (gl_prev === 1'b1) check("genlock width", gl_o, !gl_pp);
        gl_pp <= gl_prev;
        gl_prev <= gl_o;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        seed = 32'h42;
        cyc = 0;
        n_mismatch = 0;
        checked = 0;
        {pins, rgbp, fs, sf, gl_drv, gl_prev, gl_pp} = 10'h000;
        do_reset();
        send(`VME_DEV_ADDR ^ 7'h01, 8'h00, 8'hFF, 8'hFF, 2);
        for (int i = 0; i < 13; i++) begin
            pins = codes[(i + 1) % 13];
            rgbp = i[1];
            repeat (4) @(negedge clk);
            pri = {i[0], 3'(rnd()), codes[i]};
            sec = 8'(rnd());
            send(`VME_DEV_ADDR, 8'h00, pri, sec, 2);
        end
        send(`VME_DEV_ADDR, 8'h02, 8'(rnd()), 8'h00, 1);
        gl_case(1'b0, 8'h08);
        gl_case(1'b1, 8'h08);
        gl_case(1'b0, 8'h00);
        gl_case(1'b1, 8'h00);
        gl_case(1'b0, 8'h01);
        gl_case(1'b1, 8'h0A);
        repeat (20) @(negedge clk);
        check("notes left", q.size(), 0);
        final_report();
    end
endmodule // vme_mode_regs_test
`default_nettype wire
